/* File: tfs_pkg.sv */
package tfs_pkg;

   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] TFS_CMD_TURNOFF_FALL_TIME = 8'h65;
   localparam logic [7:0] TFS_CMD_FAULT_SUMMARY_BYTE = 8'h78;

   // ---------------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------------
   localparam int TFS_MANT_W = 7;
   localparam logic [TFS_MANT_W-1:0] TFS_FALL_RESET = 7'h00;
   localparam logic [15:0] TFS_ZERO_WORD = 16'h0000;
   localparam int TFS_SUM_OFF = 6;
   localparam int TFS_SUM_OVF = 5;
   localparam int TFS_SUM_OCF = 4;
   localparam int TFS_SUM_TEMP = 2;
   localparam int TFS_SUM_CML = 1;
   localparam int TFS_SUM_MISC = 0;
   localparam int TFS_VOUT_OVF = 7;
   localparam int TFS_IOUT_OCF = 7;
   localparam int TFS_IOUT_OCW = 5;
   localparam int TFS_INPUT_LOW_VIN = 3;
   // Overvoltage warn, undervoltage warn and fault, limit warning, startup timeout.
   localparam logic [7:0] TFS_VOUT_MISC_MASK = 8'h7c;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int TFS_CLK_PERIOD_NS = 40;
   localparam int TFS_FALL_UNIT_NS = 1000000;
   localparam int TFS_MS_CYCLES = TFS_FALL_UNIT_NS / TFS_CLK_PERIOD_NS;
   localparam logic [TFS_MANT_W-1:0] TFS_FASTEST_FALL_MS = 7'h01;

   // Maps a programmed mantissa onto one of the fifteen supported fall times.
   function automatic logic [TFS_MANT_W-1:0] tfs_fall_bucket(input logic [TFS_MANT_W-1:0] m);
      logic [TFS_MANT_W-1:0] r;
      r = 7'h64;
      if (m <= 7'h01)
         r = TFS_FASTEST_FALL_MS;
      else if (m <= 7'h06)
         r = m;
      else if (m <= 7'h09)
         r = 7'h07;
      else if (m <= 7'h0c)
         r = 7'h0a;
      else if (m <= 7'h11)
         r = 7'h0e;
      else if (m <= 7'h16)
         r = 7'h13;
      else if (m <= 7'h20)
         r = 7'h1b;
      else if (m <= 7'h2c)
         r = 7'h25;
      else if (m <= 7'h3e)
         r = 7'h34;
      else if (m <= 7'h56)
         r = 7'h48;
      return r;
   endfunction

endpackage

/* File: tfs_turnoff_fall.sv */
`timescale 1ns/1ns
module tfs_turnoff_fall
   import tfs_pkg::*;
#(
   parameter int MS_CYCLES = TFS_MS_CYCLES,
   parameter logic [7:0] VENDOR_MISC_MASK = 8'hff
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic loop_slave_pin,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   output logic rsp_valid,
   output logic rsp_ack,
   output logic [15:0] rsp_rdata,
   output logic invalid_command_fault,
   output logic smbalert_trigger,
   input wire logic save_all_settings,
   input wire logic restore_valid,
   input wire logic [6:0] restore_mantissa,
   output logic [6:0] nv_fall_mantissa,
   input wire logic converter_enabled,
   input wire logic [7:0] output_voltage_status,
   input wire logic [7:0] output_current_status,
   input wire logic [7:0] temperature_status,
   input wire logic [7:0] comms_status,
   input wire logic [7:0] input_status,
   input wire logic [7:0] vendor_status,
   input wire logic delay_elapsed,
   output logic [6:0] effective_fall_ms,
   output logic ramp_active,
   output logic ramp_done
);

   // A zero count would leave the millisecond timer with nothing to count.
   if (MS_CYCLES < 1)
   begin
      $error("MS_CYCLES must be at least one");
   end

   typedef enum logic {TFS_IDLE, TFS_RAMP} tfs_state_type;

   localparam int MS_W = $clog2(MS_CYCLES + 1);

   logic rst_meta;
   logic rst_n;
   logic slave_meta;
   logic loop_slave;
   logic [TFS_MANT_W-1:0] fall_mantissa;
   logic [7:0] summary;
   logic hit_fall;
   logic hit_summary;
   tfs_state_type state;
   logic [MS_W-1:0] cycle_count;
   logic [TFS_MANT_W-1:0] ms_left;
   logic last_tick;
   logic misc_vout;
   logic misc_vendor;

   // ---------------------------------------------------------------
   // Reset release and loop-slave strap synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // The strap is a pin, so only the second flop may feed any logic.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slave_meta <= 1'b0;
         loop_slave <= 1'b0;
      end
      else
      begin
         slave_meta <= loop_slave_pin;
         loop_slave <= slave_meta;
      end
   end

   // ---------------------------------------------------------------
   // Summary byte
   // ---------------------------------------------------------------
   // misc source OR
   assign misc_vout = |(output_voltage_status & TFS_VOUT_MISC_MASK);
   assign misc_vendor = |(vendor_status & VENDOR_MISC_MASK);

   // Built from live source flags so a read never shows a stale copy.
   // follows source clears
   always_comb
   begin
      summary = 8'h00;
      summary[TFS_SUM_OFF] = ~converter_enabled;
      summary[TFS_SUM_OVF] = output_voltage_status[TFS_VOUT_OVF] & ~loop_slave;
      summary[TFS_SUM_OCF] = output_current_status[TFS_IOUT_OCF];
      summary[TFS_SUM_TEMP] = |temperature_status;
      summary[TFS_SUM_CML] = |comms_status;
      summary[TFS_SUM_MISC] = misc_vout | output_current_status[TFS_IOUT_OCW]
         | input_status[TFS_INPUT_LOW_VIN] | misc_vendor;
   end

   // Other codes belong to other blocks and get no answer here.
   assign hit_fall = cmd_code == TFS_CMD_TURNOFF_FALL_TIME;
   assign hit_summary = cmd_code == TFS_CMD_FAULT_SUMMARY_BYTE;

   // ---------------------------------------------------------------
   // Response handshake
   // ---------------------------------------------------------------
   // The summary byte answers even on a loop slave; only the fall setting is refused.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsp_valid <= 1'b0;
         rsp_ack <= 1'b0;
      end
      else
      begin
         rsp_valid <= cmd_valid & (hit_fall | hit_summary);
         // slave refuses access, summary writes acked
         rsp_ack <= cmd_valid & (hit_summary | (hit_fall & ~loop_slave));
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // Data is zero outside a read answer, so a stale word never lingers.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rsp_rdata <= TFS_ZERO_WORD;
      else if (cmd_valid && !cmd_write && hit_fall && !loop_slave)
         rsp_rdata <= {9'h000, fall_mantissa};
      else if (cmd_valid && !cmd_write && hit_summary)
         rsp_rdata <= {8'h00, summary};
      else
         rsp_rdata <= TFS_ZERO_WORD;
   end

   // ---------------------------------------------------------------
   // Refused access report
   // ---------------------------------------------------------------
   // Both pulses stand for the one cycle of the refused answer.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         invalid_command_fault <= 1'b0;
         smbalert_trigger <= 1'b0;
      end
      else
      begin
         invalid_command_fault <= cmd_valid & hit_fall & loop_slave;
         smbalert_trigger <= cmd_valid & hit_fall & loop_slave;
      end
   end

   // ---------------------------------------------------------------
   // Fall time setting and its nonvolatile copy
   // ---------------------------------------------------------------
   // A host write outranks a restore that lands in the same cycle.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         fall_mantissa <= TFS_FALL_RESET;
      // only the low seven bits are stored
      else if (cmd_valid && cmd_write && hit_fall && !loop_slave)
         fall_mantissa <= cmd_wdata[TFS_MANT_W-1:0];
      else if (restore_valid)
         fall_mantissa <= restore_mantissa;
   end

   // The copy moves on the save pulse only, so later writes leave it alone.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         nv_fall_mantissa <= TFS_FALL_RESET;
      else if (save_all_settings)
         nv_fall_mantissa <= fall_mantissa;
   end

   // Registered so the bucket table never sits in the path to a pin.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         effective_fall_ms <= TFS_FASTEST_FALL_MS;
      // zero maps to fastest, bucket table
      else
         effective_fall_ms <= tfs_fall_bucket(fall_mantissa);
   end

   // ---------------------------------------------------------------
   // Fall ramp sequencing
   // ---------------------------------------------------------------
   // The ramp length is latched at its start; a rewrite mid-ramp applies next time.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= TFS_IDLE;
         ramp_active <= 1'b0;
         ramp_done <= 1'b0;
      end
      else
      begin
         ramp_done <= 1'b0;
         unique case (state)
            TFS_IDLE:
            begin
               // start only once the delay has elapsed
               if (delay_elapsed)
               begin
                  state <= TFS_RAMP;
                  ramp_active <= 1'b1;
               end
            end
            TFS_RAMP:
            begin
               // ramp lasts the effective number of milliseconds
               if (last_tick)
               begin
                  state <= TFS_IDLE;
                  ramp_active <= 1'b0;
                  ramp_done <= 1'b1;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Millisecond counters
   // ---------------------------------------------------------------
   // While idle the counters track the setting, so a start needs no extra cycle.
   assign last_tick = (cycle_count == '0) && (ms_left == TFS_FASTEST_FALL_MS);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cycle_count <= '0;
         ms_left <= '0;
      end
      else if (state == TFS_IDLE)
      begin
         cycle_count <= MS_W'(MS_CYCLES - 1);
         ms_left <= effective_fall_ms;
      end
      else if (cycle_count != '0)
         cycle_count <= cycle_count - 1'b1;
      else
      begin
         ms_left <= ms_left - 1'b1;
         cycle_count <= MS_W'(MS_CYCLES - 1);
      end
   end

endmodule

/* File: tfs_chk_sva.sv */
`timescale 1ns/1ns
module tfs_chk
   import tfs_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic loop_slave_pin,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic rsp_valid,
   input wire logic rsp_ack,
   input wire logic [15:0] rsp_rdata,
   input wire logic invalid_command_fault,
   input wire logic smbalert_trigger,
   input wire logic converter_enabled,
   input wire logic [7:0] output_current_status,
   input wire logic [7:0] temperature_status,
   input wire logic delay_elapsed,
   input wire logic [6:0] effective_fall_ms,
   input wire logic ramp_active,
   input wire logic ramp_done
);
   logic rd_sum;
   logic at_fall;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   assign rd_sum = cmd_valid && !cmd_write && cmd_code == TFS_CMD_FAULT_SUMMARY_BYTE;
   assign at_fall = cmd_valid && cmd_code == TFS_CMD_TURNOFF_FALL_TIME;
   // The pin passes a two-stage synchroniser, so it must have stood high for a while.
   slave_nack_a: assert property (loop_slave_pin [*7] ##0 at_fall |=> rsp_valid && !rsp_ack
      && invalid_command_fault && smbalert_trigger) else $error("slave access not refused");
   sum_layout_a: assert property (rd_sum |=> rsp_valid && rsp_ack && rsp_rdata[15:7] == 9'h000
      && !rsp_rdata[3]) else $error("summary layout wrong");
   unpowered_bit_a: assert property (rd_sum |=> rsp_rdata[6] == !$past(converter_enabled))
      else $error("unpowered bit wrong");
   overcur_bit_a: assert property (rd_sum |=> rsp_rdata[4] == $past(output_current_status[7]))
      else $error("overcurrent bit wrong");
   temp_bit_a: assert property (rd_sum |=> rsp_rdata[2] == |$past(temperature_status))
      else $error("temperature bit wrong");
   fall_read_a: assert property (at_fall && !cmd_write ##1 rsp_ack |-> rsp_rdata[15:7] == 9'h000)
      else $error("fall upper bits set");
   fast_fall_a: assert property (effective_fall_ms != 7'h00)
      else $error("zero fall time");
   ramp_start_a: assert property (delay_elapsed && !ramp_active |=> ramp_active)
      else $error("ramp did not start");
   ramp_end_a: assert property (ramp_done |-> $fell(ramp_active))
      else $error("ramp end misaligned");
   alert_pair_a: assert property (invalid_command_fault |-> smbalert_trigger && rsp_valid
      && !rsp_ack) else $error("refusal report incomplete");
endmodule
bind tfs_turnoff_fall tfs_chk tfs_chk_i(.clk, .arst_n, .loop_slave_pin, .cmd_valid, .cmd_write,
   .cmd_code, .rsp_valid, .rsp_ack, .rsp_rdata, .invalid_command_fault, .smbalert_trigger,
   .converter_enabled, .output_current_status, .temperature_status, .delay_elapsed,
   .effective_fall_ms, .ramp_active, .ramp_done);

/* File: tfs_host.sv */
`timescale 1ns/1ns
module tfs_host
(
   input wire logic clk,
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   input wire logic rsp_valid,
   input wire logic rsp_ack,
   input wire logic [15:0] rsp_rdata
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // The answer stands one cycle only, so it is taken at the edge that ends the request.
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
      output logic a, output logic [15:0] r);
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_code = c;
      cmd_wdata = d;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      cmd_wdata = ~d;
      a = rsp_ack;
      r = rsp_rdata;
   endtask
endmodule

/* File: tfs_turnoff_fall_tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tfs_turnoff_fall_tb
   import tfs_pkg::*;
;
   localparam int MS = 4;
   logic clk = 0, arst_n = 0, slv = 0, save = 0, dly = 0, en = 0, rsv = 0, a;
   logic cv, cw, rv, ra, icf, alr, ract, rdone;
   logic [7:0] cc, ovs, ocs, tmp, cms, ins, vds;
   logic [15:0] cd, rd, r;
   logic [6:0] nv, eff;
   logic [47:0] src = 48'h000800000000;
   int fail_count = 0, checked = 0;
   assign {vds, ins, cms, tmp, ocs, ovs} = src;
   tfs_turnoff_fall #(.MS_CYCLES(MS)) tfs_turnoff_fall_i(.clk, .arst_n, .loop_slave_pin(slv),
      .cmd_valid(cv), .cmd_write(cw), .cmd_code(cc), .cmd_wdata(cd), .rsp_valid(rv),
      .rsp_ack(ra), .rsp_rdata(rd), .invalid_command_fault(icf), .smbalert_trigger(alr),
      .save_all_settings(save), .restore_valid(rsv), .restore_mantissa(nv),
      .nv_fall_mantissa(nv), .converter_enabled(en), .output_voltage_status(ovs),
      .output_current_status(ocs), .temperature_status(tmp), .comms_status(cms),
      .input_status(ins), .vendor_status(vds), .delay_elapsed(dly), .effective_fall_ms(eff),
      .ramp_active(ract), .ramp_done(rdone));
   tfs_host tfs_host_i(.clk, .cmd_valid(cv), .cmd_write(cw), .cmd_code(cc), .cmd_wdata(cd),
      .rsp_valid(rv), .rsp_ack(ra), .rsp_rdata(rd));
   task automatic give_verdict();
      if (fail_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic t_reset();
      tfs_host_i.xfer(1'b0, TFS_CMD_TURNOFF_FALL_TIME, 16'h0000, a, r);
      `CHK("fall reset", 16'h0000, r)
      tfs_host_i.xfer(1'b0, TFS_CMD_FAULT_SUMMARY_BYTE, 16'h0000, a, r);
      `CHK("summary reset", 16'h0041, r)
      `CHK("fall ms reset", 7'h01, eff)
   endtask
   task automatic t_bucket();
      logic [6:0] m[17] = '{7'h00, 7'h01, 7'h02, 7'h06, 7'h09, 7'h0a, 7'h0d, 7'h11, 7'h16,
         7'h17, 7'h20, 7'h2c, 7'h3e, 7'h3f, 7'h56, 7'h57, 7'h7f};
      logic [6:0] e[17] = '{7'h01, 7'h01, 7'h02, 7'h06, 7'h07, 7'h0a, 7'h0e, 7'h0e, 7'h13,
         7'h1b, 7'h1b, 7'h25, 7'h34, 7'h48, 7'h48, 7'h64, 7'h64};
      for (int i = 0; i < 17; i++)
      begin
         tfs_host_i.xfer(1'b1, TFS_CMD_TURNOFF_FALL_TIME, {9'h1ff, m[i]}, a, r);
         @(posedge clk);
         #1;
         `CHK("fall ms", e[i], eff)
      end
      tfs_host_i.xfer(1'b0, TFS_CMD_TURNOFF_FALL_TIME, 16'h0000, a, r);
      `CHK("fall read", 16'h007f, r)
   endtask
   task automatic t_sum();
      logic [47:0] s[9] = '{48'h0, 48'h80, 48'h04, 48'h8000, 48'h2000, 48'h010000,
         48'h80000000, 48'h0800000000, 48'h010000000000};
      logic [7:0] e[9] = '{8'h00, 8'h20, 8'h01, 8'h10, 8'h01, 8'h04, 8'h02, 8'h01, 8'h01};
      en = 1'b1;
      for (int i = 0; i < 9; i++)
      begin
         src = s[i];
         tfs_host_i.xfer(1'b0, TFS_CMD_FAULT_SUMMARY_BYTE, 16'h0000, a, r);
         `CHK("summary", {8'h00, e[i]}, r)
      end
      tfs_host_i.xfer(1'b1, TFS_CMD_FAULT_SUMMARY_BYTE, 16'h0000, a, r);
      `CHK("summary write ack", 1'b1, a)
      tfs_host_i.xfer(1'b0, TFS_CMD_FAULT_SUMMARY_BYTE, 16'h0000, a, r);
      `CHK("summary kept", 16'h0001, r)
      src = 48'h0;
      tfs_host_i.xfer(1'b0, TFS_CMD_FAULT_SUMMARY_BYTE, 16'h0000, a, r);
      `CHK("summary cleared", 16'h0000, r)
   endtask
   task automatic t_ramp();
      int n;
      tfs_host_i.xfer(1'b1, TFS_CMD_TURNOFF_FALL_TIME, 16'h0002, a, r);
      save = 1'b1;
      @(posedge clk);
      #1;
      save = 1'b0;
      `CHK("saved copy", 7'h02, nv)
      `CHK("idle", 1'b0, ract)
      dly = 1'b1;
      @(posedge clk);
      #1;
      dly = 1'b0;
      `CHK("active", 1'b1, ract)
      n = 0;
      while (rdone !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK("ramp cycles", 2 * MS, n)
      `CHK("ramp over", 1'b0, ract)
      tfs_host_i.xfer(1'b1, TFS_CMD_TURNOFF_FALL_TIME, 16'h0005, a, r);
      rsv = 1'b1;
      @(posedge clk);
      #1;
      rsv = 1'b0;
      tfs_host_i.xfer(1'b0, TFS_CMD_TURNOFF_FALL_TIME, 16'h0000, a, r);
      `CHK("restored", 16'h0002, r)
   endtask
   task automatic t_slave();
      slv = 1'b1;
      src = 48'h80;
      repeat (8) @(posedge clk);
      tfs_host_i.xfer(1'b1, TFS_CMD_TURNOFF_FALL_TIME, 16'h0005, a, r);
      `CHK("slave ack", 1'b0, a)
      `CHK("slave fault", 2'b11, {icf, alr})
      tfs_host_i.xfer(1'b0, TFS_CMD_FAULT_SUMMARY_BYTE, 16'h0000, a, r);
      `CHK("slave summary", 16'h0000, r)
      tfs_host_i.xfer(1'b0, TFS_CMD_TURNOFF_FALL_TIME, 16'h0000, a, r);
      `CHK("slave read nack", 1'b0, a)
      slv = 1'b0;
      repeat (3) @(posedge clk);
      tfs_host_i.xfer(1'b0, TFS_CMD_TURNOFF_FALL_TIME, 16'h0000, a, r);
      `CHK("write ignored", 16'h0002, r)
   endtask
   initial
   begin
      forever #20 clk = ~clk;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (5) @(posedge clk);
      t_reset();
      t_bucket();
      t_sum();
      t_ramp();
      t_slave();
      give_verdict();
   end
   // Whole run needs well under a thousand cycles.
   initial
   begin
      #200000;
      fail_count++;
      give_verdict();
   end
endmodule
